//--- rxsc_pkg.sv
// Package: register map, field layout and timing for the sync/correlation bank
`default_nettype none
package rxsc_pkg;
	// Register byte addresses on the host register port
	localparam logic [7:0] ADDR_SOF_HIGH = 8'h5A;
	localparam logic [7:0] ADDR_SOF_LOW = 8'h5B;
	localparam logic [7:0] ADDR_SYNC_MODE = 8'h5C;
	localparam logic [7:0] ADDR_DEMOD = 8'h5D;
	localparam logic [7:0] ADDR_CORR = 8'h5E;
	localparam logic [7:0] ADDR_TRIM = 8'h5F;
	// Field positions
	localparam int SM_LEN_LSB = 4;
	localparam int SM_NEG_EDGE = 3;
	localparam int SM_HALF = 2;
	localparam int SM_TYPE_LSB = 0;
	localparam int DM_AVG = 5;
	localparam int DM_RECT = 4;
	localparam int DM_PEAK = 3;
	localparam int DM_POL = 2;
	localparam int DM_FSK = 1;
	localparam int DM_PSK = 0;
	localparam int CC_FREQ_LSB = 6;
	localparam int CC_SPEED_LSB = 4;
	localparam int CC_SHORT = 3;
	// Writable bits; the rest are reserved
	localparam logic [7:0] DEMOD_WMASK = 8'h3F;
	localparam logic [7:0] CORR_WMASK = 8'hF8;
	// Reset values
	localparam logic [7:0] RST_SOF_HIGH = 8'h00;
	localparam logic [7:0] RST_SOF_LOW = 8'h00;
	localparam logic [7:0] RST_SYNC_MODE = 8'h00;
	localparam logic [7:0] RST_DEMOD = 8'h00;
	localparam logic [7:0] RST_CORR = 8'h00;
	// Timing
	localparam int CLK_HZ = 10_000_000;
	localparam int SUBC_212_HZ = 212_000;
	localparam int SUBC_424_HZ = 424_000;
	localparam int SUBC_848_HZ = 848_000;
	localparam int SUBC_212_HALF = CLK_HZ / (2 * SUBC_212_HZ);
	localparam int SUBC_424_HALF = CLK_HZ / (2 * SUBC_424_HZ);
	localparam int SUBC_848_HALF = CLK_HZ / (2 * SUBC_848_HZ);
	localparam int PROX_BAUD = 106_000;
	localparam int BAUD_53K = 53_000;
	localparam int BAUD_26K = 26_000;
	localparam int CORR_CLKS_PROX = CLK_HZ / PROX_BAUD;
	localparam int CORR_CLKS_53K = CLK_HZ / BAUD_53K;
	localparam int CORR_CLKS_26K = CLK_HZ / BAUD_26K;
	localparam int CORR_LEN_LONG = 64;
	localparam int CORR_LEN_SHORT = 32;
	localparam int AVG_SAMPLES = 4;

	typedef enum logic [1:0] {SYNC_BURST, SYNC_SYMBOL, SYNC_BYTE, SYNC_RFU}
		rxsc_sync_e;
	typedef enum logic [1:0] {DEMOD_ASK, DEMOD_FSK, DEMOD_PHASE_SHIFT_DEMOD} rxsc_demod_e;

	typedef struct packed {
		logic [3:0] sof_pattern_length;
		logic negative_edge_grid;
		logic half_length_final_sof_bit;
		rxsc_sync_e sof_interpretation_type;
		logic four_sample_average;
		logic rectangular_shaping;
		logic grid_at_correlation_peak;
		logic manchester_polarity_select;
		rxsc_demod_e demod;
		logic [7:0] subc_half_period;
		logic [9:0] correlation_clock_count;
		logic [6:0] corr_length;
		logic [7:0] receiver_trim;
	} rxsc_cfg_s;
endpackage
`default_nettype wire

//--- rxsc_four_sample_average.sv
// Sample pre-filter: four-sample averaging and rectangular shaping
`timescale 1ns/10ps
`default_nettype none
module rxsc_four_sample_average (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Controls
	input wire logic avg_en_i,
	input wire logic rect_en_i,
	// Converter samples in, filtered samples out
	input wire logic [7:0] sample_i,
	input wire logic sample_valid_i,
	output logic [7:0] data_o,
	output logic data_valid_o
);
	import rxsc_pkg::*;
	logic [9:0] acc_ff;
	logic [1:0] cnt_ff;
	logic [7:0] shaped;
	logic [8:0] dev;

	// Doubles the distance from mid-scale and clips, squaring the edges
	always_comb begin
		dev = 9'h000;
		shaped = sample_i;
		if (rect_en_i) begin
			if (sample_i[7]) begin
				dev = {1'b0, sample_i - 8'h80} << 1;
				shaped = (dev >= 9'h080) ? 8'hFF : 8'(9'h080 + dev);
			end else begin
				dev = {1'b0, 8'h80 - sample_i} << 1;
				shaped = (dev >= 9'h080) ? 8'h00 : 8'(9'h080 - dev);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !avg_en_i) begin
			acc_ff <= 10'h000;
			cnt_ff <= 2'h0;
		end else if (sample_valid_i) begin
			cnt_ff <= cnt_ff + 2'h1;
			acc_ff <= (cnt_ff == 2'(AVG_SAMPLES - 1)) ? 10'h000 :
				acc_ff + {2'h0, shaped};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_o <= 8'h00;
			data_valid_o <= 1'b0;
		end else begin
			data_valid_o <= 1'b0;
			if (sample_valid_i && !avg_en_i) begin
				data_o <= shaped;
				data_valid_o <= 1'b1;
			end else if (sample_valid_i &&
				cnt_ff == 2'(AVG_SAMPLES - 1)) begin
				data_o <= 8'((acc_ff + {2'h0, shaped}) >> 2);
				data_valid_o <= 1'b1;
			end
		end
	end

	AST_AVG_EVERY_FOURTH: assert property (@(posedge clk_i) disable iff (rst_i)
		avg_en_i && sample_valid_i && cnt_ff != 2'h3 |=> !data_valid_o)
		else $error("averaged output before fourth sample");
endmodule
`default_nettype wire

//--- rxsc_grid.sv
// Bit-grid placement from the correlation stream
`timescale 1ns/10ps
`default_nettype none
module rxsc_grid (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Controls
	input wire logic peak_i,
	input wire logic neg_edge_i,
	input wire logic arm_i,
	input wire logic [6:0] corr_len_i,
	// Correlation values
	input wire logic signed [11:0] corr_i,
	input wire logic corr_valid_i,
	// Grid mark and window end
	output logic grid_o,
	output logic window_end_o
);
	import rxsc_pkg::*;
	logic signed [11:0] prev_ff;
	logic rising_ff;
	logic armed_ff;
	logic [6:0] idx_ff;
	logic turn;

	// A turn is where the slope flips at a maximum or a minimum
	assign turn = peak_i ? (rising_ff && corr_i < prev_ff)
		: (!rising_ff && corr_i > prev_ff);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_ff <= 12'sh000;
			rising_ff <= 1'b0;
		end else if (corr_valid_i) begin
			prev_ff <= corr_i;
			rising_ff <= corr_i > prev_ff;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || arm_i)
			armed_ff <= 1'b1;
		else if (corr_valid_i && neg_edge_i && !prev_ff[11] && corr_i[11])
			armed_ff <= 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || arm_i)
			idx_ff <= 7'h00;
		else if (corr_valid_i)
			idx_ff <= (idx_ff == corr_len_i - 7'h01) ? 7'h00 : idx_ff + 7'h01;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			grid_o <= 1'b0;
			window_end_o <= 1'b0;
		end else begin
			window_end_o <= corr_valid_i && idx_ff == corr_len_i - 7'h01;
			if (neg_edge_i)
				grid_o <= corr_valid_i && armed_ff && !prev_ff[11]
					&& corr_i[11];
			else
				grid_o <= corr_valid_i && turn;
		end
	end

	AST_NEG_EDGE_ONCE: assert property (@(posedge clk_i) disable iff (rst_i)
		neg_edge_i && grid_o ##1 (!arm_i && neg_edge_i) [*3] |-> !grid_o)
		else $error("second grid mark without rearm");
	AST_WINDOW_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
		window_end_o |-> $past(idx_ff) == $past(corr_len_i) - 7'h01)
		else $error("window end at wrong index");
endmodule
`default_nettype wire

//--- rxsc_top.sv
// Receiver start-of-frame sync and correlation configuration bank
`timescale 1ns/10ps
`default_nettype none
module rxsc_top (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Host register port
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// Boot trim value
	input wire logic [7:0] trim_boot_i,
	// Converter samples
	input wire logic [7:0] sample_i,
	input wire logic sample_valid_i,
	output logic [7:0] filt_data_o,
	output logic filt_valid_o,
	// Correlation stream
	input wire logic signed [11:0] corr_i,
	input wire logic corr_valid_i,
	output logic grid_o,
	output logic window_end_o,
	// Received bits for start-of-frame search
	input wire logic frame_start_i,
	input wire logic rx_bit_i,
	input wire logic rx_coll_i,
	input wire logic rx_bit_valid_i,
	input wire logic start_bit_i,
	output logic sof_found_o,
	output logic resync_o,
	output logic [9:0] bit_period_o,
	// Manchester halves to logical bits
	input wire logic half_first_i,
	input wire logic half_second_i,
	input wire logic half_valid_i,
	output logic data_bit_o,
	output logic data_coll_o,
	output logic data_valid_o,
	// Decoded configuration
	output rxsc_pkg::rxsc_cfg_s cfg_o
);
	import rxsc_pkg::*;

	logic [7:0] sof_high_ff;
	logic [7:0] sof_low_ff;
	logic [7:0] sync_mode_ff;
	logic [7:0] demod_ff;
	logic [7:0] corr_ff;
	logic [7:0] trim_ff;
	logic [7:0] nxt_rdata;
	rxsc_cfg_s cfg;
	logic [15:0] pattern;
	logic [15:0] hist_ff;
	logic [15:0] coll_ff;
	logic [4:0] seen_ff;
	logic armed_ff;
	logic [15:0] burst_mask;
	logic [7:0] sym_ok;
	logic burst_hit;
	logic sym_hit;
	logic [3:0] sym_len;

	// Register writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sof_high_ff <= RST_SOF_HIGH;
			sof_low_ff <= RST_SOF_LOW;
		end else if (reg_wr_i) begin
			if (reg_addr_i == ADDR_SOF_HIGH)
				sof_high_ff <= reg_wdata_i;
			if (reg_addr_i == ADDR_SOF_LOW)
				sof_low_ff <= reg_wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_mode_ff <= RST_SYNC_MODE;
			demod_ff <= RST_DEMOD;
			corr_ff <= RST_CORR;
		end else if (reg_wr_i) begin
			if (reg_addr_i == ADDR_SYNC_MODE)
				sync_mode_ff <= reg_wdata_i;
			if (reg_addr_i == ADDR_DEMOD)
				demod_ff <= reg_wdata_i & DEMOD_WMASK;
			if (reg_addr_i == ADDR_CORR)
				corr_ff <= reg_wdata_i & CORR_WMASK;
		end
	end

	// Trim loads the boot value in reset; software is expected not to touch it
	always_ff @(posedge clk_i) begin
		if (rst_i)
			trim_ff <= trim_boot_i;
		else if (reg_wr_i && reg_addr_i == ADDR_TRIM)
			trim_ff <= reg_wdata_i;
	end

	// Register reads, answered one cycle later
	always_comb begin
		case (reg_addr_i)
			ADDR_SOF_HIGH: nxt_rdata = sof_high_ff;
			ADDR_SOF_LOW: nxt_rdata = sof_low_ff;
			ADDR_SYNC_MODE: nxt_rdata = sync_mode_ff;
			ADDR_DEMOD: nxt_rdata = demod_ff;
			ADDR_CORR: nxt_rdata = corr_ff;
			ADDR_TRIM: nxt_rdata = trim_ff;
			default: nxt_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= 8'h00;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i)
				reg_rdata_o <= nxt_rdata;
		end
	end

	// Decode of the stored settings
	always_comb begin
		cfg.sof_pattern_length = sync_mode_ff[SM_LEN_LSB +: 4];
		cfg.negative_edge_grid = sync_mode_ff[SM_NEG_EDGE];
		cfg.half_length_final_sof_bit = sync_mode_ff[SM_HALF];
		cfg.sof_interpretation_type =
			rxsc_sync_e'(sync_mode_ff[SM_TYPE_LSB +: 2]);
		cfg.four_sample_average = demod_ff[DM_AVG];
		cfg.rectangular_shaping = demod_ff[DM_RECT];
		cfg.grid_at_correlation_peak = demod_ff[DM_PEAK];
		cfg.manchester_polarity_select = demod_ff[DM_POL];
		if (demod_ff[DM_FSK])
			cfg.demod = DEMOD_FSK;
		else if (demod_ff[DM_PSK])
			cfg.demod = DEMOD_PHASE_SHIFT_DEMOD;
		else
			cfg.demod = DEMOD_ASK;
		case (corr_ff[CC_FREQ_LSB +: 2])
			2'h0: cfg.subc_half_period = 8'(SUBC_212_HALF);
			2'h1: cfg.subc_half_period = 8'(SUBC_424_HALF);
			default: cfg.subc_half_period = 8'(SUBC_848_HALF);
		endcase
		case (corr_ff[CC_SPEED_LSB +: 2])
			2'h0: cfg.correlation_clock_count = 10'(CORR_CLKS_PROX);
			2'h1: cfg.correlation_clock_count = 10'(CORR_CLKS_53K);
			2'h2: cfg.correlation_clock_count = 10'(CORR_CLKS_26K);
			default: cfg.correlation_clock_count = 10'(CORR_CLKS_PROX);
		endcase
		cfg.corr_length = corr_ff[CC_SHORT] ? 7'(CORR_LEN_SHORT)
			: 7'(CORR_LEN_LONG);
		cfg.receiver_trim = trim_ff;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			cfg_o <= '0;
		else
			cfg_o <= cfg;
	end

	// Sample pre-filter
	rxsc_four_sample_average u_four_sample_average (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.avg_en_i(cfg_o.four_sample_average),
		.rect_en_i(cfg_o.rectangular_shaping),
		.sample_i(sample_i),
		.sample_valid_i(sample_valid_i),
		.data_o(filt_data_o),
		.data_valid_o(filt_valid_o)
	);

	// Bit-grid placement
	rxsc_grid u_grid (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.peak_i(cfg_o.grid_at_correlation_peak),
		.neg_edge_i(cfg_o.negative_edge_grid),
		.arm_i(frame_start_i),
		.corr_len_i(cfg_o.corr_length),
		.corr_i(corr_i),
		.corr_valid_i(corr_valid_i),
		.grid_o(grid_o),
		.window_end_o(window_end_o)
	);

	// Start-of-frame search: newest bit enters at position zero
	assign pattern = {sof_high_ff, sof_low_ff};
	assign burst_mask = 16'((17'h00001 << cfg.sof_pattern_length) - 17'h00001);
	assign burst_hit = ((hist_ff ^ pattern) & burst_mask) == 16'h0000;
	assign sym_len = (cfg.sof_pattern_length > 4'h8) ? 4'h8
		: cfg.sof_pattern_length;

	// Symbol k pairs data in bit 2k+1 with the collision flag in bit 2k
	genvar k;
	generate
		for (k = 0; k < 8; k++) begin : g_sym
			assign sym_ok[k] = (4'(k) >= sym_len) ||
				(pattern[2*k] ? coll_ff[k]
				: (!coll_ff[k] && hist_ff[k] == pattern[2*k+1]));
		end
	endgenerate
	assign sym_hit = &sym_ok;

	always_ff @(posedge clk_i) begin
		if (rst_i || frame_start_i) begin
			hist_ff <= 16'h0000;
			coll_ff <= 16'h0000;
			seen_ff <= 5'h00;
		end else if (rx_bit_valid_i && armed_ff) begin
			hist_ff <= {hist_ff[14:0], rx_bit_i};
			coll_ff <= {coll_ff[14:0], rx_coll_i};
			if (seen_ff != 5'h10)
				seen_ff <= seen_ff + 5'h01;
		end
	end

	// Match is checked the cycle after each bit arrives
	logic check_ff;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			check_ff <= 1'b0;
		else
			check_ff <= rx_bit_valid_i && armed_ff && !frame_start_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || frame_start_i) begin
			armed_ff <= !rst_i;
			sof_found_o <= 1'b0;
		end else begin
			sof_found_o <= 1'b0;
			if (check_ff && armed_ff && cfg.sof_pattern_length != 4'h0) begin
				case (cfg.sof_interpretation_type)
					SYNC_BURST: begin
						if (burst_hit &&
							seen_ff >= {1'b0, cfg.sof_pattern_length}) begin
							sof_found_o <= 1'b1;
							armed_ff <= 1'b0;
						end
					end
					SYNC_SYMBOL: begin
						if (sym_hit && seen_ff >= {1'b0, sym_len}) begin
							sof_found_o <= 1'b1;
							armed_ff <= 1'b0;
						end
					end
					default: ;
				endcase
			end
		end
	end

	// Byte-wise resync on start bits; the reserved type does nothing
	always_ff @(posedge clk_i) begin
		if (rst_i)
			resync_o <= 1'b0;
		else
			resync_o <= start_bit_i && cfg.sof_interpretation_type == SYNC_BYTE;
	end

	// Bit period, halved for the final bit of the sync sequence
	always_ff @(posedge clk_i) begin
		if (rst_i)
			bit_period_o <= 10'(CORR_CLKS_PROX);
		else if (cfg.half_length_final_sof_bit && armed_ff &&
			seen_ff + 5'h01 == {1'b0, cfg.sof_pattern_length})
			bit_period_o <= cfg.correlation_clock_count >> 1;
		else
			bit_period_o <= cfg.correlation_clock_count;
	end

	// Manchester halves to a logical bit; equal halves mark a collision
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_bit_o <= 1'b0;
			data_coll_o <= 1'b0;
			data_valid_o <= 1'b0;
		end else begin
			data_valid_o <= half_valid_i;
			if (half_valid_i) begin
				data_bit_o <= cfg.manchester_polarity_select ^ half_first_i;
				data_coll_o <= half_first_i == half_second_i;
			end
		end
	end

	sequence s_wr_demod;
		reg_wr_i && reg_addr_i == ADDR_DEMOD;
	endsequence
	sequence s_rd_demod;
		reg_rd_i && reg_addr_i == ADDR_DEMOD && !reg_wr_i;
	endsequence

	AST_RSVD_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
		s_wr_demod ##[1:8] s_rd_demod |=> reg_rdata_o[7:6] == 2'h0)
		else $error("reserved demod bits read nonzero");
	AST_CORR_RSVD: assert property (@(posedge clk_i) disable iff (rst_i)
		corr_ff[2:0] == 3'h0)
		else $error("reserved correlation bits stored");
	AST_FSK_WINS: assert property (@(posedge clk_i) disable iff (rst_i)
		demod_ff[DM_FSK] |=> cfg_o.demod == DEMOD_FSK)
		else $error("frequency shift not selected");
	AST_ASK_DEFAULT: assert property (@(posedge clk_i) disable iff (rst_i)
		demod_ff[1:0] == 2'h0 |=> cfg_o.demod == DEMOD_ASK)
		else $error("default scheme not selected");
	AST_SUBC_848: assert property (@(posedge clk_i) disable iff (rst_i)
		corr_ff[7] |=> cfg_o.subc_half_period == 8'(SUBC_848_HALF))
		else $error("wrong subcarrier for codes two and three");
	AST_SHORT_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
		corr_ff[CC_SHORT] |=> cfg_o.corr_length == 7'h20)
		else $error("short correlation length not 32");
	AST_RESYNC: assert property (@(posedge clk_i) disable iff (rst_i)
		start_bit_i && sync_mode_ff[1:0] == 2'h2 |=> resync_o)
		else $error("no resync on start bit");
	AST_ONE_SOF: assert property (@(posedge clk_i) disable iff (rst_i)
		sof_found_o ##1 !frame_start_i [*2] |-> !sof_found_o)
		else $error("second start of frame without new frame");
	AST_POLARITY: assert property (@(posedge clk_i) disable iff (rst_i)
		half_valid_i && !demod_ff[DM_POL] |=>
		data_bit_o == $past(half_first_i))
		else $error("Manchester mapping wrong");
endmodule
`default_nettype wire

//--- rx_sync_correlation_config_bench.sv
// Self-checking bench for the sync and correlation configuration bank
`timescale 1ns/10ps
`default_nettype none
module rx_sync_correlation_config_bench;
	import rxsc_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr = 8'h00, wdat = 8'h00, boot = 8'h00, smp = 8'h00;
	logic wr = 1'b0, rd = 1'b0, sv = 1'b0, cv = 1'b0, fs = 1'b0, sb = 1'b0;
	logic rb = 1'b0, rc = 1'b0, rbv = 1'b0, h1 = 1'b0, h2 = 1'b0, hv = 1'b0;
	logic signed [11:0] corr = 12'sh000;
	logic [7:0] rdata, fdata;
	logic rvalid, fvalid, grid, wend, sof, rsy, dbit, dcoll, dvalid;
	logic [9:0] bper;
	rxsc_cfg_s cfg;
	int n_mismatch = 0;
	int tests_run = 0;
	logic [7:0] m [6];
	bit qb [$];
	bit qc [$];
	int e_pk [4] = '{10, 20, 30, 25};
	int e_mn [3] = '{20, 10, 15};

	rxsc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdat),
		.reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .trim_boot_i(boot),
		.sample_i(smp), .sample_valid_i(sv), .filt_data_o(fdata),
		.filt_valid_o(fvalid), .corr_i(corr), .corr_valid_i(cv),
		.grid_o(grid), .window_end_o(wend), .frame_start_i(fs),
		.rx_bit_i(rb), .rx_coll_i(rc), .rx_bit_valid_i(rbv),
		.start_bit_i(sb), .sof_found_o(sof), .resync_o(rsy),
		.bit_period_o(bper), .half_first_i(h1), .half_second_i(h2),
		.half_valid_i(hv), .data_bit_o(dbit), .data_coll_o(dcoll),
		.data_valid_o(dvalid), .cfg_o(cfg));

	always #50 clk_i = ~clk_i;

	task automatic conclude();
		$display("mismatches %0d checks %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string w);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %h exp %h", $time, w, got, exp);
		end
	endtask

	task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_i);
		rd <= 1'b0;
		#1;
		tests_run++;
		if (rvalid !== 1'b1 || rdata !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: read %h got %h exp %h", $time, a, rdata,
				exp);
		end
	endtask

	// Write, update the model, and wait until the decoded settings follow
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr <= 1'b1;
		addr <= a;
		wdat <= d;
		@(posedge clk_i);
		wr <= 1'b0;
		if (a >= ADDR_SOF_HIGH && a <= ADDR_TRIM) begin
			m[a - ADDR_SOF_HIGH] = d & (a == ADDR_DEMOD ? DEMOD_WMASK :
				a == ADDR_CORR ? CORR_WMASK : 8'hFF);
		end
		@(posedge clk_i);
		#1;
	endtask

	task automatic samp(input logic [7:0] d);
		@(posedge clk_i);
		smp <= d;
		sv <= 1'b1;
		@(posedge clk_i);
		sv <= 1'b0;
		#1;
	endtask

	task automatic cfeed(input int v);
		@(posedge clk_i);
		corr <= 12'(v);
		cv <= 1'b1;
		@(posedge clk_i);
		cv <= 1'b0;
		#1;
	endtask

	task automatic rxb(input bit b, input bit c);
		@(posedge clk_i);
		rb <= b;
		rc <= c;
		rbv <= 1'b1;
		@(posedge clk_i);
		rbv <= 1'b0;
		qb.push_back(b);
		qc.push_back(c);
		@(posedge clk_i);
		#1;
	endtask

	function automatic int rect_model(input int x);
		int y;
		y = x >= 128 ? 128 + 2 * (x - 128) : 128 - 2 * (128 - x);
		return y > 255 ? 255 : (y < 0 ? 0 : y);
	endfunction

	// Newest bit sits against pattern bit 0
	function automatic bit sof_hit(input int typ, input int len,
		input logic [15:0] p);
		int n;
		n = typ == 0 ? len : (len > 8 ? 8 : len);
		if (len == 0 || typ > 1 || qb.size() < n) return 0;
		for (int k = 0; k < n; k++) begin
			if (typ == 0 && qb[$-k] != p[k]) return 0;
			if (typ == 1 && p[2*k] && !qc[$-k]) return 0;
			if (typ == 1 && !p[2*k] && qb[$-k] != p[2*k+1]) return 0;
		end
		return 1;
	endfunction

	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		conclude();
	end

	initial begin
		logic [7:0] d;
		logic [15:0] pat;
		int e, sum, typ, len, j;
		bit armed, hit, b, c;
		void'($urandom(32'hE15D));
		boot = 8'($urandom);
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 5; i++) m[i] = 8'h00;
		m[5] = boot;
		@(posedge clk_i);
		#1;
		chk(16'(bper), 16'(CORR_CLKS_PROX), "reset period");
		for (int i = 0; i < 6; i++) chk_reg(ADDR_SOF_HIGH + 8'(i), m[i]);
		chk_reg(8'h60, 8'h00);
		chk_reg(8'h00, 8'h00);
		for (int i = 0; i < 5; i++) begin
			wr_reg(ADDR_SOF_HIGH + 8'(i), 8'($urandom));
			chk_reg(ADDR_SOF_HIGH + 8'(i), m[i]);
		end
		wr_reg(ADDR_TRIM, boot);
		chk_reg(ADDR_TRIM, boot);
		chk(cfg.receiver_trim, boot, "trim");
		for (int i = 0; i < 4; i++) begin
			d = 8'($urandom);
			wr_reg(ADDR_SYNC_MODE, {d[7:2], i[1:0]});
			chk(cfg.sof_pattern_length, m[2][7:4], "length");
			chk(cfg.negative_edge_grid, m[2][3], "negedge");
			chk(cfg.half_length_final_sof_bit, m[2][2], "half");
			chk(cfg.sof_interpretation_type, m[2][1:0], "type");
			d = 8'($urandom);
			wr_reg(ADDR_DEMOD, {d[7:2], i[1:0]});
			chk_reg(ADDR_DEMOD, m[3]);
			chk(cfg.four_sample_average, m[3][5], "avg");
			chk(cfg.rectangular_shaping, m[3][4], "rect");
			chk(cfg.grid_at_correlation_peak, m[3][3], "peak");
			chk(cfg.manchester_polarity_select, m[3][2], "pol");
			e = i[1] ? DEMOD_FSK : (i[0] ? DEMOD_PHASE_SHIFT_DEMOD : DEMOD_ASK);
			chk(cfg.demod, 16'(e), "demod");
			wr_reg(ADDR_CORR, {i[1:0], i[1:0], i[0], 3'b111});
			chk_reg(ADDR_CORR, m[4]);
			e = i == 0 ? SUBC_212_HALF : (i == 1 ? SUBC_424_HALF : SUBC_848_HALF);
			chk(cfg.subc_half_period, 16'(e), "subcarrier");
			e = i == 1 ? CORR_CLKS_53K : (i == 2 ? CORR_CLKS_26K : CORR_CLKS_PROX);
			chk(cfg.correlation_clock_count, 16'(e), "speed");
			chk(cfg.corr_length, i[0] ? 16'h0020 : 16'h0040, "corr len");
		end
		wr_reg(ADDR_DEMOD, 8'h20);
		sum = 0;
		for (int k = 0; k < 4; k++) begin
			d = 8'($urandom);
			sum += d;
			samp(d);
			chk(fvalid, k == 3, "avg valid");
		end
		chk(fdata, 16'(sum / 4), "avg data");
		wr_reg(ADDR_DEMOD, 8'h10);
		repeat (4) begin
			d = 8'($urandom);
			samp(d);
			chk(fdata, 16'(rect_model(d)), "rect data");
		end
		wr_reg(ADDR_DEMOD, 8'h00);
		d = 8'($urandom);
		samp(d);
		chk({fvalid, fdata}, {1'b1, d}, "plain sample");
		for (int p = 0; p < 2; p++) begin
			wr_reg(ADDR_DEMOD, 8'(p * 4));
			for (int k = 0; k < 4; k++) begin
				@(posedge clk_i);
				h1 <= k[1];
				h2 <= k[0];
				hv <= 1'b1;
				@(posedge clk_i);
				hv <= 1'b0;
				#1;
				chk({dvalid, dbit, dcoll}, {1'b1, p[0] ^ k[1], k[1] == k[0]},
					"manchester");
			end
		end
		wr_reg(ADDR_SYNC_MODE, 8'h02);
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_i);
			sb <= 1'b1;
			@(posedge clk_i);
			sb <= 1'b0;
			#1;
			chk(rsy, k == 0, "resync");
			wr_reg(ADDR_SYNC_MODE, 8'h03);
		end
		wr_reg(ADDR_DEMOD, 8'h08);
		foreach (e_pk[k]) begin
			cfeed(e_pk[k]);
			chk(grid, k == 3, "grid max");
		end
		wr_reg(ADDR_DEMOD, 8'h00);
		foreach (e_mn[k]) begin
			cfeed(e_mn[k]);
			chk(grid, k == 2, "grid min");
		end
		wr_reg(ADDR_SYNC_MODE, 8'h08);
		@(posedge clk_i);
		fs <= 1'b1;
		@(posedge clk_i);
		fs <= 1'b0;
		cfeed(5);
		chk(grid, 1'b0, "neg grid early");
		cfeed(-3);
		chk(grid, 1'b1, "neg grid");
		for (int r = 0; r < 3; r++) begin
			typ = r == 1 ? 1 : 0;
			len = r == 0 ? 4 : (r == 1 ? 2 : 0);
			pat = 16'($urandom);
			wr_reg(ADDR_SOF_HIGH, pat[15:8]);
			wr_reg(ADDR_SOF_LOW, pat[7:0]);
			wr_reg(ADDR_SYNC_MODE, {len[3:0], 2'b01, typ[1:0]});
			@(posedge clk_i);
			fs <= 1'b1;
			@(posedge clk_i);
			fs <= 1'b0;
			@(posedge clk_i);
			#1;
			qb.delete();
			qc.delete();
			armed = 1'b1;
			for (int k = 0; k < len + 2; k++) begin
				e = armed && k + 1 == len ? CORR_CLKS_PROX / 2 : CORR_CLKS_PROX;
				chk(16'(bper), 16'(e), "bit period");
				j = len - 1 - k;
				b = 1'($urandom);
				c = 1'b0;
				if (k < len && typ == 0) b = pat[j];
				if (k < len && typ == 1) c = pat[2*j];
				if (k < len && typ == 1 && !c) b = pat[2*j+1];
				rxb(b, c);
				hit = armed && sof_hit(typ, len, pat);
				chk(sof, hit, "sof");
				if (hit) armed = 1'b0;
			end
		end
		wr_reg(ADDR_CORR, 8'h08);
		for (int k = 0; k < CORR_LEN_SHORT; k++) begin
			cfeed(k);
			chk(wend, k == CORR_LEN_SHORT - 1, "window end");
		end
		conclude();
	end
endmodule
`default_nettype wire
